//--- hw/dcl_top.v
// DMA channel status sequencing, live readback, preemption and linking
`timescale 1ns/1ns
`include "dcl_map.vh"
module dcl_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [11:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire [3:0]  hw_req_i,
  output reg  [3:0]  hw_ack_o,
  output wire        xfer_valid_o,
  input  wire        xfer_ready_i,
  output reg  [31:0] xfer_src_o,
  output reg  [31:0] xfer_dst_o
);
  // Descriptor local memory and per-channel working register file
  reg [31:0] src_q  [0:3];
  reg [31:0] dst_q  [0:3];
  reg [31:0] nby_q  [0:3];
  reg [15:0] cit_q  [0:3];
  reg [15:0] bit_q  [0:3];
  reg [15:0] ctl_q  [0:3];
  reg [31:0] wsrc_q [0:3];
  reg [31:0] wdst_q [0:3];
  reg [31:0] wnby_q [0:3];
  reg [3:0]  start_q;
  reg [3:0]  active_q;
  reg [3:0]  done_q;
  reg [3:0]  cerr_q;
  reg [3:0]  hwen_q;
  reg        rr_q;
  reg [1:0]  state_q;
  reg [1:0]  cur_q;
  reg [1:0]  sus_q;
  reg        sus_v_q;
  reg [1:0]  last_q;
  integer    i;

  // Bus decode
  wire       bus_req  = cyc_i && stb_i && !ack_o;
  wire       top_ok   = (adr_i[`DCL_ADR_TOP] == 3'h0);
  wire       is_glb   = top_ok && adr_i[`DCL_ADR_GLB];
  wire       is_ch    = top_ok && !adr_i[`DCL_ADR_GLB] &&
                        !adr_i[`DCL_ADR_HOLE];
  wire [1:0] bch      = adr_i[`DCL_ADR_CH];
  wire [2:0] bwd      = adr_i[`DCL_ADR_WORD];
  wire       bus_wr   = bus_req && we_i;
  wire [31:0] lane    = {{8{sel_i[3]}}, {8{sel_i[2]}},
                         {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Byte-lane merge of write data into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [31:0] msk;
    begin
      merge = (old & ~msk) | (dat & msk);
    end
  endfunction

  // Arbitration input: start bits plus enabled peripheral requests
  wire [3:0] req = (start_q | (hw_req_i & hwen_q)) & ~active_q;
  wire [7:0] prio = {ctl_q[3][`DCL_CTL_PRIO], ctl_q[2][`DCL_CTL_PRIO],
                     ctl_q[1][`DCL_CTL_PRIO], ctl_q[0][`DCL_CTL_PRIO]};
  wire [1:0] gnt;
  wire       gnt_v;

  dcl_arbiter u_arb (
    .req_i   (req),
    .prio_i  (prio),
    .rr_i    (rr_q),
    .last_i  (last_q),
    .grant_o (gnt),
    .valid_o (gnt_v)
  );

  // Preemption: fixed mode only, one level deep, strictly higher priority
  wire pre_go = (state_q == `DCL_ST_RUN) && !rr_q && !sus_v_q &&
                ctl_q[cur_q][`DCL_CTL_PRE] && gnt_v &&
                (ctl_q[gnt][`DCL_CTL_PRIO] >
                 ctl_q[cur_q][`DCL_CTL_PRIO]);
  wire start_go = gnt_v && ((state_q == `DCL_ST_IDLE) || pre_go);
  wire cfg_bad  = cit_q[gnt][`DCL_IT_ELINK] !=
                  bit_q[gnt][`DCL_IT_ELINK];

  // Beat handshake toward the system bus
  assign xfer_valid_o = (state_q == `DCL_ST_RUN) && !pre_go;
  wire beat     = xfer_valid_o && xfer_ready_i;
  wire last_bt  = wnby_q[cur_q] <= `DCL_BEAT;

  // Iteration count width depends on the minor link enable
  wire [15:0] cit_c = cit_q[cur_q];
  wire        elink = cit_c[`DCL_IT_ELINK];
  wire [14:0] cnt   = elink ? {6'h00, cit_c[`DCL_IT_CNT9]} :
                              cit_c[`DCL_IT_CNT15];
  wire [14:0] ncnt  = cnt - 15'h0001;
  wire        major = (cnt == 15'h0000) || (ncnt == 15'h0000);
  wire [15:0] cit_n = elink ? {cit_c[`DCL_IT_HI], ncnt[8:0]} :
                              {cit_c[`DCL_IT_ELINK], ncnt};

  // Merged 32-bit images of the 16-bit words; only the low half is kept
  wire [31:0] cit_wm = merge({16'h0000, cit_q[bch]}, dat_i, lane);
  wire [31:0] bit_wm = merge({16'h0000, bit_q[bch]}, dat_i, lane);
  wire [31:0] ctl_wm = merge({16'h0000, ctl_q[bch]}, dat_i, lane);

  // Control word write: chain enable forced low while done is set
  wire [15:0] ctl_w = ctl_wm[15:0];
  wire [15:0] ctl_m = done_q[bch] ?
                      (ctl_w & ~(16'h0001 << `DCL_CTL_MCE)) : ctl_w;

  // Engine, descriptor memory and status bits share one process so that
  // the order of clear, software write and link set is explicit
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < `DCL_NCH; i = i + 1) begin
        src_q[i]  <= 32'h0000_0000;
        dst_q[i]  <= 32'h0000_0000;
        nby_q[i]  <= 32'h0000_0000;
        cit_q[i]  <= 16'h0000;
        bit_q[i]  <= 16'h0000;
        ctl_q[i]  <= 16'h0000;
        wsrc_q[i] <= 32'h0000_0000;
        wdst_q[i] <= 32'h0000_0000;
        wnby_q[i] <= 32'h0000_0000;
      end
      start_q  <= 4'h0;
      active_q <= 4'h0;
      done_q   <= 4'h0;
      cerr_q   <= 4'h0;
      hwen_q   <= 4'h0;
      rr_q     <= 1'b0;
      state_q  <= `DCL_ST_IDLE;
      cur_q    <= 2'h0;
      sus_q    <= 2'h0;
      sus_v_q  <= 1'b0;
      last_q   <= 2'h0;
      hw_ack_o <= 4'h0;
    end else begin
      hw_ack_o <= 4'h0;
      // Software writes first; engine updates below override them
      if (bus_wr && is_glb) begin
        case (bwd)
          `DCL_G_MODE: if (sel_i[0])
            rr_q <= dat_i[`DCL_MODE_RR];
          `DCL_G_HWEN: if (sel_i[0])
            hwen_q <= dat_i[3:0];
          `DCL_G_CERR: if (sel_i[0])
            cerr_q <= cerr_q & ~dat_i[3:0];
          default: ;
        endcase
      end
      if (bus_wr && is_ch) begin
        case (bwd)
          `DCL_W_SRC: src_q[bch] <= merge(src_q[bch], dat_i, lane);
          `DCL_W_DST: dst_q[bch] <= merge(dst_q[bch], dat_i, lane);
          `DCL_W_NBY: nby_q[bch] <= merge(nby_q[bch], dat_i, lane);
          `DCL_W_CIT: cit_q[bch] <= cit_wm[15:0];
          `DCL_W_BIT: bit_q[bch] <= bit_wm[15:0];
          `DCL_W_CTL: begin
            ctl_q[bch] <= ctl_m & `DCL_CTL_RWMASK;
            if (sel_i[0]) begin
              start_q[bch] <= dat_i[`DCL_CTL_START];
              // Software can only clear done (launch also clears it); writing one is ignored
              if (!dat_i[`DCL_CTL_DONE])
                done_q[bch] <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      // Channel launch from idle or as a preempting channel
      if (start_go) begin
        start_q[gnt] <= 1'b0;
        last_q       <= gnt;
        if (!start_q[gnt])
          hw_ack_o[gnt] <= 1'b1;
        if (cfg_bad) begin
          cerr_q[gnt] <= 1'b1;
        end else begin
          done_q[gnt]   <= 1'b0;
          active_q[gnt] <= 1'b1;
          wsrc_q[gnt]   <= src_q[gnt];
          wdst_q[gnt]   <= dst_q[gnt];
          wnby_q[gnt]   <= nby_q[gnt];
          cur_q         <= gnt;
          state_q       <= `DCL_ST_RUN;
          if (pre_go) begin
            // Suspended channel keeps active and its working values
            sus_q   <= cur_q;
            sus_v_q <= 1'b1;
          end
        end
      end else begin
        case (state_q)
          `DCL_ST_RUN: if (beat) begin
            wsrc_q[cur_q] <= wsrc_q[cur_q] + `DCL_BEAT;
            wdst_q[cur_q] <= wdst_q[cur_q] + `DCL_BEAT;
            wnby_q[cur_q] <= last_bt ? 32'h0000_0000 :
                             wnby_q[cur_q] - `DCL_BEAT;
            if (last_bt)
              state_q <= `DCL_ST_END;
          end
          `DCL_ST_END: begin
            src_q[cur_q]    <= wsrc_q[cur_q];
            dst_q[cur_q]    <= wdst_q[cur_q];
            active_q[cur_q] <= 1'b0;
            if (major) begin
              cit_q[cur_q]  <= bit_q[cur_q];
              done_q[cur_q] <= 1'b1;
              // Chain enable is taken from memory now, not at launch
              if (ctl_q[cur_q][`DCL_CTL_MCE])
                start_q[ctl_q[cur_q][`DCL_CTL_MCT]] <= 1'b1;
            end else begin
              cit_q[cur_q] <= cit_n;
              if (elink)
                start_q[cit_c[`DCL_IT_LINK]] <= 1'b1;
            end
            // Resume the suspended channel after one iteration
            if (sus_v_q) begin
              cur_q   <= sus_q;
              sus_v_q <= 1'b0;
              state_q <= `DCL_ST_RUN;
            end else begin
              state_q <= `DCL_ST_IDLE;
            end
          end
          default: state_q <= `DCL_ST_IDLE;
        endcase
      end
    end
  end

  // Beat addresses track the next working value, so that they are
  // already right at the first beat after a launch or a resume
  always @(posedge clk_i) begin
    if (rst_i) begin
      xfer_src_o <= 32'h0000_0000;
      xfer_dst_o <= 32'h0000_0000;
    end else if (start_go && !cfg_bad) begin
      xfer_src_o <= src_q[gnt];
      xfer_dst_o <= dst_q[gnt];
    end else if (beat) begin
      xfer_src_o <= wsrc_q[cur_q] + `DCL_BEAT;
      xfer_dst_o <= wdst_q[cur_q] + `DCL_BEAT;
    end else if ((state_q == `DCL_ST_END) && sus_v_q) begin
      // Suspended channel continues from its own working pointers
      xfer_src_o <= wsrc_q[sus_q];
      xfer_dst_o <= wdst_q[sus_q];
    end
  end

  // Read mux: live values for active channels, memory for the rest
  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    if (is_ch) begin
      case (bwd)
        `DCL_W_SRC: rd = active_q[bch] ? wsrc_q[bch] : src_q[bch];
        `DCL_W_DST: rd = active_q[bch] ? wdst_q[bch] : dst_q[bch];
        `DCL_W_NBY: rd = active_q[bch] ? wnby_q[bch] : nby_q[bch];
        `DCL_W_CIT: rd = {16'h0000, cit_q[bch]};
        `DCL_W_BIT: rd = {16'h0000, bit_q[bch]};
        `DCL_W_CTL: rd = {16'h0000, ctl_q[bch][15:3], done_q[bch],
                          active_q[bch], start_q[bch]};
        default:    rd = 32'h0000_0000;
      endcase
    end else if (is_glb) begin
      case (bwd)
        `DCL_G_MODE: rd = {31'h0000_0000, rr_q};
        `DCL_G_HWEN: rd = {28'h000_0000, hwen_q};
        `DCL_G_CERR: rd = {28'h000_0000, cerr_q};
        `DCL_G_ACT:  rd = {28'h000_0000, active_q};
        default:     rd = 32'h0000_0000;
      endcase
    end
  end

  // Wishbone answer one cycle after the request; unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i)
        dat_o <= rd;
    end
  end
endmodule

//--- common/dcl_map.vh
// Register map, field positions and constants of the DMA status/link block
`ifndef DCL_MAP_VH
`define DCL_MAP_VH
`define DCL_NCH        4
`define DCL_CHW        2
// Byte address decode: channel region versus global region
`define DCL_ADR_TOP    11:9
`define DCL_ADR_GLB    8
`define DCL_ADR_HOLE   7
`define DCL_ADR_CH     6:5
`define DCL_ADR_WORD   4:2
// Descriptor word indexes inside a channel region (32 bytes per channel)
`define DCL_W_SRC      3'h0
`define DCL_W_DST      3'h1
`define DCL_W_NBY      3'h2
`define DCL_W_CIT      3'h3
`define DCL_W_BIT      3'h4
`define DCL_W_CTL      3'h5
// Global registers (word index within global region)
`define DCL_G_MODE     3'h0
`define DCL_G_HWEN     3'h1
`define DCL_G_CERR     3'h2
`define DCL_G_ACT      3'h3
`define DCL_MODE_RR    0
// descriptor_control_word fields
`define DCL_CTL_START  0
`define DCL_CTL_ACTIVE 1
`define DCL_CTL_DONE   2
`define DCL_CTL_MCE    3
`define DCL_CTL_MCT    9:8
`define DCL_CTL_PRE    12
`define DCL_CTL_PRIO   15:14
`define DCL_CTL_RWMASK 16'hD308
// Iteration words: link enable, link target, count fields
`define DCL_IT_ELINK   15
`define DCL_IT_LINK    10:9
`define DCL_IT_HI      15:9
`define DCL_IT_CNT9    8:0
`define DCL_IT_CNT15   14:0
// Engine states and transfer beat
`define DCL_ST_IDLE    2'h0
`define DCL_ST_RUN     2'h1
`define DCL_ST_END     2'h2
`define DCL_BEAT       32'h0000_0004
`endif

//--- hw/dcl_arbiter.v
// Channel arbiter: fixed priority or descending round robin
`timescale 1ns/1ns
`include "dcl_map.vh"
module dcl_arbiter (
  input  wire [3:0] req_i,
  input  wire [7:0] prio_i,
  input  wire       rr_i,
  input  wire [1:0] last_i,
  output reg  [1:0] grant_o,
  output reg        valid_o
);
  integer   i;
  reg [1:0] best;
  reg [1:0] idx;

  // Fixed: highest priority wins, ties go to the higher channel number
  always @* begin
    grant_o = 2'h0;
    valid_o = 1'b0;
    best    = 2'h0;
    idx     = 2'h0;
    if (rr_i) begin
      // Rotate downward from the channel below the last one served
      for (i = 1; i <= `DCL_NCH; i = i + 1) begin
        idx = last_i - i[1:0];
        if (req_i[idx] && !valid_o) begin
          grant_o = idx;
          valid_o = 1'b1;
        end
      end
    end else begin
      for (i = 0; i < `DCL_NCH; i = i + 1) begin
        if (req_i[i] && (!valid_o || prio_i[2*i +: 2] >= best)) begin
          grant_o = i[1:0];
          best    = prio_i[2*i +: 2];
          valid_o = 1'b1;
        end
      end
    end
  end
endmodule

//--- testbench/dcl_checker.sv
// Port checker for the DMA status and linking block
`timescale 1ns/1ns
module dcl_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [11:0] adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire [3:0]  hw_req_i,
  input wire [3:0]  hw_ack_o,
  input wire        xfer_valid_o,
  input wire        xfer_ready_i,
  input wire [31:0] xfer_src_o,
  input wire [31:0] xfer_dst_o
);
  wire rd_ack;
  wire ctl_rd;
  wire beat;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Read answers decoded once for the status checks
  assign rd_ack = ack_o && !we_i;
  assign ctl_rd = rd_ack && adr_i[11:7] == 5'h00 && adr_i[4:2] == 3'h5;
  assign beat   = xfer_valid_o && xfer_ready_i;
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_hole_zero: assert property (rd_ack && (adr_i[11:9] != 3'h0 ||
    adr_i[7]) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_start_cleared: assert property (ctl_rd |->
    !(dat_o[0] && dat_o[1]))
    else $error("start and active both set");
  chk_active_pair: assert property (rd_ack && adr_i == 12'h10C |->
    dat_o[31:4] == 28'h0 && $countones(dat_o) <= 2)
    else $error("too many active channels");
  chk_beat_step: assert property (beat ##1 beat |->
    xfer_src_o == $past(xfer_src_o) + 32'h4 &&
    xfer_dst_o == $past(xfer_dst_o) + 32'h4)
    else $error("pointers did not advance by one beat");
  chk_stall_hold: assert property (xfer_valid_o && !xfer_ready_i ##1
    xfer_valid_o |-> $stable(xfer_src_o) && $stable(xfer_dst_o))
    else $error("beat address changed while stalled");
  chk_hwack_req: assert property (|hw_ack_o |->
    (hw_ack_o & ~$past(hw_req_i)) == 4'h0)
    else $error("launch ack without peripheral request");
  cov_beats: cover property (beat ##1 beat);
  cov_hw: cover property (|hw_ack_o);
  cov_two_act: cover property (rd_ack && adr_i == 12'h10C &&
    dat_o[3:0] == 4'h3);
endmodule
bind dcl_top dcl_checker CHK (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .dat_o, .ack_o, .hw_req_i, .hw_ack_o, .xfer_valid_o,
  .xfer_ready_i, .xfer_src_o, .xfer_dst_o);

//--- testbench/dcl_far_model.sv
// Far side model: beat sink with quota and peripheral request sources
`timescale 1ns/1ns
module dcl_far_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        valid_i,
  input  wire [31:0] src_i,
  input  wire [3:0]  ack_i,
  input  wire [7:0]  lim_i,
  input  wire        slow_i,
  input  wire [3:0]  req_i,
  output wire        ready_o,
  output reg  [3:0]  hw_req_o,
  output reg  [7:0]  beats_o,
  output reg  [31:0] last_src_o
);
  reg tog_q;
  // Quota lets the bench freeze a channel mid-loop; slow mode stalls
  assign ready_o = (beats_o < lim_i) && (!slow_i || tog_q);
  // Requests stay up until the engine acknowledges the launch
  always @(posedge clk_i) begin
    if (rst_i) begin
      tog_q <= 1'b0;
      hw_req_o <= 4'h0;
      beats_o <= 8'h00;
      last_src_o <= 32'h0;
    end else begin
      tog_q <= ~tog_q;
      hw_req_o <= (hw_req_o | req_i) & ~ack_i;
      if (valid_i && ready_o) begin
        beats_o <= beats_o + 8'h01;
        last_src_o <= src_i;
      end
    end
  end
endmodule

//--- testbench/dcl_top_bench.sv
// Bench for the DMA status and linking block
`timescale 1ns/1ns
module dcl_top_bench;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i, slow;
  reg  [11:0] adr_i;
  reg  [3:0]  sel_i, rq;
  reg  [31:0] dat_i, rdat;
  reg  [7:0]  lim;
  wire [31:0] dat_o, src, dst, lsrc;
  wire        ack_o, vld, rdy;
  wire [3:0]  hreq, hack;
  wire [7:0]  bt;
  integer     n_mismatch, compares, cyc_n, m;
  dcl_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .hw_req_i(hreq), .hw_ack_o(hack),
    .xfer_valid_o(vld), .xfer_ready_i(rdy), .xfer_src_o(src),
    .xfer_dst_o(dst));
  dcl_far_model FAR (.clk_i(clk_i), .rst_i(rst_i), .valid_i(vld),
    .src_i(src), .ack_i(hack), .lim_i(lim), .slow_i(slow), .req_i(rq),
    .ready_o(rdy), .hw_req_o(hreq), .beats_o(bt), .last_src_o(lsrc));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  function [11:0] ra(input integer c, input integer w);
    ra = {5'h00, c[1:0], w[2:0], 2'h0};
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // One classic cycle: hold everything until ack is sampled high
  task bus(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rdat = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk(rdat, e);
    end
  endtask
  task cfg(input integer c, input [31:0] s, input [31:0] n,
           input [31:0] it);
    begin
      wr(ra(c, 0), s);
      wr(ra(c, 1), s + 32'h1000);
      wr(ra(c, 2), n);
      wr(ra(c, 3), it);
      wr(ra(c, 4), it);
    end
  endtask
  // End state lands one cycle after the last beat
  task wb(input [7:0] n);
    begin
      while (bt < n) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
    end
  endtask
  task hw;
    begin
      rq <= 4'h2;
      @(posedge clk_i);
      rq <= 4'h0;
      while (hack !== 4'h2) @(posedge clk_i);
    end
  endtask
  task report_and_stop;
    begin
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {cyc_i, stb_i, we_i, slow, adr_i, dat_i, lim, rq} = 0;
    {n_mismatch, compares, cyc_n} = 0;
    sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(ra(0, 5), 32'h0);
    wr(12'h0C0, 32'hFFFF);
    rc(12'h0C0, 32'h0);
    sel_i <= 4'h0;
    wr(ra(0, 0), 32'h55);
    sel_i <= 4'hF;
    rc(ra(0, 0), 32'h0);
    // Software start frozen after two of four beats
    cfg(0, 32'h1000, 32'h10, 32'h1);
    lim <= 8'h02;
    slow <= 1'b1;
    wr(ra(0, 5), 32'h1);
    wb(8'h02);
    rc(ra(0, 5), 32'h2);
    rc(ra(0, 0), 32'h1008);
    rc(ra(0, 1), 32'h2008);
    rc(ra(0, 2), 32'h8);
    rc(ra(0, 3), 32'h1);
    lim <= 8'h04;
    slow <= 1'b0;
    wb(8'h04);
    rc(ra(0, 5), 32'h4);
    // Restart with done set, then link to channel 1 while running
    cfg(1, 32'h3000, 32'h4, 32'h1);
    cfg(0, 32'h1000, 32'h4, 32'h1);
    wr(ra(0, 5), 32'h5);
    rc(ra(0, 5), 32'h2);
    wr(ra(0, 5), 32'h108);
    rc(ra(0, 5), 32'h10A);
    lim <= 8'h06;
    wb(8'h06);
    rc(ra(1, 5), 32'h4);
    chk(lsrc, 32'h3000);
    wr(ra(0, 5), 32'h8);
    rc(ra(0, 5), 32'h0);
    wr(ra(0, 5), 32'h8);
    rc(ra(0, 5), 32'h8);
    wr(ra(0, 5), 32'h0);
    // Minor link from channel 2 to channel 3, two iterations
    lim <= 8'hFF;
    cfg(3, 32'h5000, 32'h4, 32'h1);
    cfg(2, 32'h4000, 32'h4, 32'h8602);
    wr(ra(2, 5), 32'h1);
    wb(8'h08);
    rc(ra(2, 3), 32'h8601);
    rc(ra(2, 5), 32'h0);
    rc(ra(3, 5), 32'h4);
    wr(ra(3, 5), 32'h0);
    wr(ra(2, 5), 32'h1);
    wb(8'h09);
    rc(ra(2, 5), 32'h4);
    rc(ra(3, 5), 32'h0);
    rc(ra(2, 3), 32'h8602);
    // Link off: bits above nine belong to the count
    cfg(1, 32'h3000, 32'h4, 32'h0401);
    wr(ra(1, 5), 32'h1);
    wb(8'h0A);
    rc(ra(1, 3), 32'h0400);
    rc(ra(1, 5), 32'h0);
    // Link enable differs between the two iteration words
    wr(ra(3, 3), 32'h8001);
    wr(ra(3, 5), 32'h1);
    rc(12'h108, 32'h8);
    rc(ra(3, 5), 32'h0);
    wr(12'h108, 32'h8);
    rc(12'h108, 32'h0);
    // Peripheral activation over the two iterations of one major loop
    cfg(1, 32'h3000, 32'h4, 32'h2);
    wr(12'h104, 32'h2);
    lim <= 8'h0A;
    hw;
    rc(ra(1, 5), 32'h2);
    lim <= 8'hFF;
    wb(8'h0B);
    rc(ra(1, 5), 32'h0);
    rc(ra(1, 3), 32'h1);
    hw;
    wb(8'h0C);
    rc(ra(1, 5), 32'h4);
    wr(12'h104, 32'h0);
    // Preemption under fixed mode, none under round robin
    for (m = 0; m < 2; m = m + 1) begin
      wr(12'h100, m);
      cfg(1, 32'h3000, 32'h8, 32'h1);
      cfg(0, 32'h1000, 32'h4, 32'h1);
      lim <= 8'h0D + 8'h03 * m[7:0];
      wr(ra(1, 5), 32'h1001);
      wr(ra(0, 5), 32'hC001);
      rc(12'h10C, m ? 32'h2 : 32'h3);
      lim <= 8'hFF;
      wb(8'h0F + 8'h03 * m[7:0]);
      chk(lsrc, m ? 32'h1000 : 32'h3004);
      rc(ra(1, 5), 32'h1004);
    end
    report_and_stop;
  end
endmodule
